// ==== sdsdl_far_model.sv ====
// Far-side comparator and strobe ordering model for the DLL block
`timescale 1ns/1ps
`default_nettype none
module sdsdl_far_model
(
  input wire logic aclk,
  input wire logic [6:0] meter,
  input wire logic [6:0] target,
  input wire logic [3:0] skew,
  output logic phase_early,
  output logic phase_late,
  output logic [3:0] strobe_early,
  output logic [3:0] clock_early
);
  // ==========
  // Comparator
  // Answers one cycle late, as a sampled analogue comparator would
  logic [9:0] out_r = 10'h000;
  assign {phase_early, phase_late, strobe_early, clock_early} = out_r;
  always @(posedge aclk)
  begin
    out_r <= {meter > target, meter < target, skew, ~skew};
  end
endmodule
`default_nettype wire

// ==== sdsdl_pkg.sv ====
// Package for the SDRAM strobe DLL control block
package sdsdl_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] SDSDL_STATUS_ADDR = 4'h0;
  localparam logic [3:0] SDSDL_CTRL_ADDR = 4'h4;
  localparam logic [3:0] SDSDL_TUNE_ADDR = 4'h8;
  localparam logic [31:0] SDSDL_RESET_VAL = 32'h00000000;
  localparam logic [1:0] SDSDL_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDSDL_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Control field positions
  localparam int SDSDL_CTL_EN = 24;
  localparam int SDSDL_CTL_FLMR = 23;
  localparam int SDSDL_CTL_LMR_LO = 20;
  localparam int SDSDL_CTL_SPARE = 19;
  localparam int SDSDL_CTL_FDIR = 18;
  localparam int SDSDL_CTL_FINC = 17;
  localparam int SDSDL_CTL_FDEC = 16;
  // ==========================================================
  // Status field positions
  localparam int SDSDL_ST_LMR_LO = 20;
  localparam int SDSDL_ST_LOCK = 18;
  localparam int SDSDL_ST_INC = 17;
  localparam int SDSDL_ST_DEC = 16;
  localparam int SDSDL_ST_FLAG_LO = 8;
  localparam int SDSDL_ST_METER_LO = 0;
  // ==========================================================
  // Counter limits and settling time
  localparam logic [6:0] SDSDL_METER_MAX = 7'h7F;
  localparam int SDSDL_SETTLE_NS = 100;
  localparam int SDSDL_CLK_NS = 20;
  localparam int SDSDL_SETTLE_CYC = (SDSDL_SETTLE_NS + SDSDL_CLK_NS - 1) / SDSDL_CLK_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    SDSDL_SEL_DEF = 2'b00,
    SDSDL_SEL_ALT = 2'b01,
    SDSDL_SEL_ZERO = 2'b10,
    SDSDL_SEL_ONE = 2'b11
  } sdsdl_sel_e;
  typedef enum logic [1:0]
  {
    SDSDL_ST_IDLE = 2'b00,
    SDSDL_ST_STEP = 2'b01,
    SDSDL_ST_WAIT = 2'b10
  } sdsdl_fsm_e;
  typedef struct packed
  {
    logic en;
    logic force_lmr;
    logic [2:0] lmr;
    logic spare;
    logic force_dir;
    logic inc;
    logic dec;
    logic [11:0] sel;
  } sdsdl_ctl_s;
endpackage

// ==== sdsdl_top.sv ====
// SDRAM strobe DLL control and observation logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Master line delays doubled reference, inverted compare
// - Comparator drives FSM stepping bar-code counter
// - Four strobes pass matched delay lines
// - Spare sixth line replaces faulty line
// - Status bits 22:20 show bar-code controls
// - Status lock, increasing, reducing flags 18:16
// - Per-strobe clock-first odd, strobe-first even flags
// - Status bits 6:0 show counter position
// - Control bit 24 enables, clear holds reset
// - Bit 23 forces bar-code controls from 22:20
// - Bit 19 substitutes line 5 for 4
// - Bit 18 forces increasing/reducing from 17:16
// - Six two-bit selects: default, alternative, 0, 1
// - Default tune: master 2, strobes 0,1,3,4
// - Alternative tune: master 3, strobes 1,2,4,5
// - Write-only four-bit fine trims per line
// - Forcing and status allow delay-line testing
module sdsdl_top
  import sdsdl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic phase_early,
  input wire logic phase_late,
  input wire logic [3:0] strobe_early,
  input wire logic [3:0] clock_early,
  output logic [2:0] lmr_ctl,
  output logic [6:0] meter,
  output logic [5:0] line_trim_bit,
  output logic [23:0] fine_trim_fields,
  output logic spare_line_substitute
);
  // ==========================================================
  // Register storage
  sdsdl_ctl_s ctl_r;
  logic [23:0] trim_r;
  logic [6:0] meter_r;
  logic [6:0] meter_nxt;
  logic [2:0] lmr_r;
  logic lock_r;
  logic inc_r;
  logic dec_r;
  logic [3:0] clk_first_r;
  logic [3:0] strb_first_r;
  logic [3:0] settle_r;
  sdsdl_fsm_e fsm_r;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic inc_eff;
  logic dec_eff;
  logic [31:0] status_word;
  logic [31:0] ctl_merged;
  logic [31:0] trim_merged;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Picks the trim field feeding a line; tune indices fold line 4 and 5 into one pair
  function automatic logic pick_tune(input logic [1:0] sel, input logic [5:0] tune_bits,
                                     input int def_idx, input int alt_idx);
    logic res;
    res = 1'b0;
    unique case (sel)
      SDSDL_SEL_DEF: res = tune_bits[def_idx];
      SDSDL_SEL_ALT: res = tune_bits[alt_idx];
      SDSDL_SEL_ZERO: res = 1'b0;
      SDSDL_SEL_ONE: res = 1'b1;
    endcase
    return res;
  endfunction

  // ==========================================================
  // AXI4-Lite write path
  wire logic do_write = aw_held_r && w_held_r && !bvalid;
  assign awready = !aw_held_r && !bvalid;
  assign wready = !w_held_r && !bvalid;
  assign ctl_merged = merge_bytes({7'h00, ctl_r[20:12], 4'h0, ctl_r.sel}, w_data_r, w_strb_r);
  assign trim_merged = merge_bytes({8'h00, trim_r}, w_data_r, w_strb_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= SDSDL_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_r == SDSDL_CTRL_ADDR || aw_addr_r == SDSDL_TUNE_ADDR)
                 ? SDSDL_RESP_OKAY : SDSDL_RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // Control registers are write-only; reads of them return zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_r <= '0;
      trim_r <= 24'h000000;
    end
    else if (do_write)
    begin
      if (aw_addr_r == SDSDL_CTRL_ADDR)
      begin
        ctl_r <= sdsdl_ctl_s'({ctl_merged[SDSDL_CTL_EN:SDSDL_CTL_FDEC], ctl_merged[11:0]});
      end
      if (aw_addr_r == SDSDL_TUNE_ADDR)
      begin
        trim_r <= trim_merged[23:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= SDSDL_RESET_VAL;
      rresp <= SDSDL_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= (araddr == SDSDL_STATUS_ADDR) ? status_word : 32'h00000000;
      rresp <= (araddr == SDSDL_STATUS_ADDR || araddr == SDSDL_CTRL_ADDR ||
                araddr == SDSDL_TUNE_ADDR) ? SDSDL_RESP_OKAY : SDSDL_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Status word
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[SDSDL_ST_LMR_LO +: 3] = lmr_r;
    status_word[SDSDL_ST_LOCK] = lock_r;
    status_word[SDSDL_ST_INC] = inc_r;
    status_word[SDSDL_ST_DEC] = dec_r;
    for (int i = 0; i < 4; i++)
    begin
      status_word[SDSDL_ST_FLAG_LO + 2*i] = strb_first_r[i];
      status_word[SDSDL_ST_FLAG_LO + 2*i + 1] = clk_first_r[i];
    end
    status_word[SDSDL_ST_METER_LO +: 7] = meter_r;
  end

  // ==========================================================
  // Phase comparator and step machine
  // direction forcing
  assign inc_eff = ctl_r.force_dir ? ctl_r.inc : phase_late;
  assign dec_eff = ctl_r.force_dir ? ctl_r.dec : phase_early;

  // flags held at zero while disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctl_r.en)
    begin
      inc_r <= 1'b0;
      dec_r <= 1'b0;
      lock_r <= 1'b0;
      clk_first_r <= 4'h0;
      strb_first_r <= 4'h0;
    end
    else
    begin
      inc_r <= inc_eff;
      dec_r <= dec_eff;
      lock_r <= !inc_eff && !dec_eff;
      clk_first_r <= clock_early;
      strb_first_r <= strobe_early;
    end
  end

  // Step machine is synchronous here; a settle wait stands in for the delay line response
  always_comb
  begin
    meter_nxt = meter_r;
    if (inc_r && !dec_r && meter_r != SDSDL_METER_MAX)
    begin
      meter_nxt = meter_r + 7'h01;
    end
    else if (dec_r && !inc_r && meter_r != 7'h00)
    begin
      meter_nxt = meter_r - 7'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctl_r.en)
    begin
      fsm_r <= SDSDL_ST_IDLE;
      meter_r <= 7'h00;
      settle_r <= 4'h0;
    end
    else
    begin
      unique case (fsm_r)
        SDSDL_ST_IDLE:
        begin
          if (inc_r != dec_r)
          begin
            fsm_r <= SDSDL_ST_STEP;
          end
        end
        SDSDL_ST_STEP:
        begin
          meter_r <= meter_nxt;
          settle_r <= 4'(SDSDL_SETTLE_CYC - 1);
          fsm_r <= SDSDL_ST_WAIT;
        end
        SDSDL_ST_WAIT:
        begin
          if (settle_r == 4'h0)
          begin
            fsm_r <= SDSDL_ST_IDLE;
          end
          else
          begin
            settle_r <= settle_r - 4'h1;
          end
        end
        default:
        begin
          fsm_r <= SDSDL_ST_IDLE;
        end
      endcase
    end
  end

  // Three-phase code rotates with the meter value modulo three
  // forced bar-code controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctl_r.en)
    begin
      lmr_r <= 3'h0;
    end
    else if (ctl_r.force_lmr)
    begin
      lmr_r <= ctl_r.lmr;
    end
    else
    begin
      unique case (meter_r % 7'd3)
        7'd0: lmr_r <= 3'b100;
        7'd1: lmr_r <= 3'b010;
        default: lmr_r <= 3'b001;
      endcase
    end
  end

  // ==========================================================
  // Delay line control outputs
  // master line shares the meter; inversion and compare live in the analogue line
  assign meter = meter_r;
  assign lmr_ctl = lmr_r;
  assign fine_trim_fields = trim_r;
  assign spare_line_substitute = ctl_r.spare;

  // Bit 0 of each trim field is the line's tuning select input; full fields go out too
  logic [5:0] tune_lsb;
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      tune_lsb[i] = trim_r[4*i];
    end
  end

  assign line_trim_bit[0] = pick_tune(ctl_r.sel[1:0], tune_lsb, 2, 3);
  assign line_trim_bit[1] = pick_tune(ctl_r.sel[3:2], tune_lsb, 0, 1);
  assign line_trim_bit[2] = pick_tune(ctl_r.sel[5:4], tune_lsb, 1, 2);
  assign line_trim_bit[3] = pick_tune(ctl_r.sel[7:6], tune_lsb, 3, 4);
  assign line_trim_bit[4] = pick_tune(ctl_r.sel[9:8], tune_lsb, 4, 5);
  assign line_trim_bit[5] = pick_tune(ctl_r.sel[11:10], tune_lsb, 4, 5);

  // ==========================================================
  // Checks
  // forcing paths observable
  chk_force_dir_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r.en && ctl_r.force_dir |=> inc_r == $past(ctl_r.inc) && dec_r == $past(ctl_r.dec))
    else $error("forced direction not reflected");
  chk_disable_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl_r.en |=> meter_r == 7'h00 && !lock_r && !inc_r && !dec_r)
    else $error("disabled loop not cleared");
  chk_lmr_force: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r.en && ctl_r.force_lmr |=> lmr_r == $past(ctl_r.lmr))
    else $error("forced lmr mismatch");
  chk_status_meter: assert property (@(posedge aclk) disable iff (!aresetn)
    status_word[6:0] == meter_r && status_word[22:20] == lmr_r)
    else $error("status meter mismatch");
  sequence step_seq;
    fsm_r == SDSDL_ST_STEP && inc_r && !dec_r && meter_r != SDSDL_METER_MAX;
  endsequence
  chk_meter_step: assert property (@(posedge aclk) disable iff (!aresetn || !ctl_r.en)
    step_seq |=> meter_r == $past(meter_r) + 7'h01)
    else $error("meter did not step up");
  chk_lock_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_r.en && !ctl_r.force_dir |=> lock_r == !($past(phase_early) || $past(phase_late)))
    else $error("lock flag does not follow comparator");
  chk_spare_out: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr_r == SDSDL_CTRL_ADDR && w_strb_r[2]
    |=> spare_line_substitute == $past(w_data_r[SDSDL_CTL_SPARE]))
    else $error("spare select mismatch");
  chk_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid)
    else $error("write response missing");
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the SDRAM strobe DLL control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdsdl_pkg::*;
  // ==========
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pe, pl, spare;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, t;
  logic [3:0] se, ce;
  logic [6:0] target = 7'h00;
  logic [3:0] skew = 4'h0;
  logic [2:0] lmr;
  logic [6:0] meter;
  logic [5:0] ltb, e;
  logic [23:0] ftf;
  logic [31:0] seed = 32'h78FC10C7;
  int fail_count = 0;
  int check_count = 0;
  int dix[6] = '{2, 0, 1, 3, 4, 4};
  int aix[6] = '{3, 1, 2, 4, 5, 5};
  sdsdl_top u_sdsdl_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .phase_early(pe), .phase_late(pl), .strobe_early(se), .clock_early(ce), .lmr_ctl(lmr),
    .meter(meter), .line_trim_bit(ltb), .fine_trim_fields(ftf), .spare_line_substitute(spare));
  sdsdl_far_model u_sdsdl_far_model (.aclk(aclk), .meter(meter), .target(target),
    .skew(skew), .phase_early(pe), .phase_late(pl), .strobe_early(se), .clock_early(ce));
  // ==========
  // Model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] lx(int m);
    return 3'h4 >> (m % 3);
  endfunction
  function automatic logic [31:0] xs(int m, int k, int i, int d, int l, logic [3:0] s);
    logic [31:0] v;
    v = 32'(m) | (32'(l) << 20) | (32'(k) << 18) | (32'(i) << 17) | (32'(d) << 16);
    for (int n = 0; n < 4; n++)
      v |= (32'(s[n]) << (8 + 2 * n)) | (32'(!s[n]) << (9 + 2 * n));
    return v;
  endfunction
  task automatic cmp(input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask
  // Write and read hold every signal until their own handshake edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    rs = bresp;
    if (n >= 50) fail_count++;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (n >= 50) fail_count++;
  endtask
  task automatic st(input logic [31:0] x);
    rd_reg(SDSDL_STATUS_ADDR);
    cmp(x, rd);
  endtask
  // Bounded wait, then margin for settling and saturation
  task automatic wait_meter(input logic [6:0] v);
    int n;
    n = 0;
    while (meter !== v && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (20) @(posedge aclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Clock, watchdog, tests
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  initial
  begin
    #400000;
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd_reg(4'(4 * i));
      cmp(32'h00000000, rd);
      cmp(32'(SDSDL_RESP_OKAY), 32'(rs));
    end
    rd_reg(4'hC);
    cmp(32'(SDSDL_RESP_SLVERR), 32'(rs));
    cmp(32'h00000000, rd);
    wr(4'hC, rnd());
    cmp(32'(SDSDL_RESP_SLVERR), 32'(rs));
    $display("test registers done");
    repeat (3)
    begin
      target <= 7'(rnd() % 126 + 1);
      skew <= 4'(rnd());
      wr(SDSDL_CTRL_ADDR, 32'h01000000);
      cmp(32'(SDSDL_RESP_OKAY), 32'(rs));
      wait_meter(target);
      cmp(32'(target), 32'(meter));
      cmp(32'(lx(target)), 32'(lmr));
      st(xs(target, 1, 0, 0, lx(target), skew));
      wr(SDSDL_CTRL_ADDR, 32'h00000000);
      repeat (2) @(posedge aclk);
      cmp(32'h00000000, 32'(meter));
      st(32'h00000000);
    end
    $display("test lock done");
    target <= 7'h40;
    wr(SDSDL_CTRL_ADDR, 32'h01060000);
    wait_meter(7'h7F);
    st(xs(127, 0, 1, 0, lx(127), skew));
    wr(SDSDL_CTRL_ADDR, 32'h01050000);
    wait_meter(7'h00);
    st(xs(0, 0, 0, 1, lx(0), skew));
    $display("test force direction done");
    target <= 7'h00;
    for (int v = 0; v < 8; v++)
    begin
      wr(SDSDL_CTRL_ADDR, 32'h01800000 | (32'(v) << 20) | (32'(v & 1) << 19));
      repeat (2) @(posedge aclk);
      cmp(32'(v), 32'(lmr));
      cmp(32'(v & 1), 32'(spare));
      st(xs(0, 1, 0, 0, v, skew));
    end
    $display("test force controls done");
    for (int m = 0; m < 4; m++)
    begin
      t = 32'h00000000;
      for (int f = 0; f < 6; f++)
        if (rnd() & 32'h1) t |= 32'hF << (4 * f);
      wr(SDSDL_TUNE_ADDR, t);
      wr(SDSDL_CTRL_ADDR, 32'h01000000 | {20'h00000, {6{2'(m)}}});
      for (int l = 0; l < 6; l++)
        e[l] = (m == 0) ? t[4 * dix[l]] : (m == 1) ? t[4 * aix[l]] : (m == 3);
      cmp(32'(e), 32'(ltb));
      cmp(t, 32'(ftf));
      rd_reg(SDSDL_TUNE_ADDR);
      cmp(32'h00000000, rd);
    end
    // Byte strobes: only the low byte of the trim register may change
    wstrb <= 4'h1;
    wr(SDSDL_TUNE_ADDR, ~t);
    wstrb <= 4'hF;
    cmp(32'({t[23:8], ~t[7:0]}), 32'(ftf));
    $display("test selects done");
    close_out();
  end
endmodule
`default_nettype wire
